// [src/reset_initialization_sequencer.sv]
// Contract
// - Primary clock is the dedicated input in host mode, PCI clock in agent mode.
// - Device holds its hard and soft reset outputs at least 512 sync periods.
// - Soft reset releases at least 16 sync periods after hard reset releases.
// - Hard and soft reset pins are open drain, only pulled low.
// - Device stops driving config pins promptly once hard reset asserts.
// - Device resumes config drive at least one sync period after hard reset negates.
// - Host mode sync period derives from primary clock by the divide setting.
// - PLL lock awaited at most 100 us before relying on derived clocks.
// - DLL lock awaited between 7680 and 122880 bus clock cycles.
`timescale 1ns/1ns
`default_nettype none

module reset_initialization_sequencer #(
    parameter int DLL_MIN_CYCLES = reset_seq_pkg::DLL_LOCK_MIN_CYCLES,
    parameter int DLL_MAX_CYCLES = reset_seq_pkg::DLL_LOCK_MAX_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    // Reset pins
    input wire logic power_on_reset_n,
    input wire logic hard_reset_n_in,
    output logic hard_reset_n_out,
    output logic hard_reset_n_oe,
    input wire logic soft_reset_n_in,
    output logic soft_reset_n_out,
    output logic soft_reset_n_oe,
    // Clocking
    input wire logic sync_clk_in,
    input wire logic pll_locked,
    input wire logic dll_locked,
    output logic pci_clk_select,
    // Configuration pins
    input wire logic host_mode_in,
    input wire logic [2:0] cfg_reset_source_in,
    input wire logic cfg_clkin_div_in,
    output logic [3:0] cfg_out,
    output logic cfg_oe,
    // Status
    output logic [2:0] cfg_reset_source,
    output logic cfg_clkin_div,
    output logic host_mode,
    output logic seq_done,
    output logic pll_fault,
    output logic dll_fault
);
    import reset_seq_pkg::*;

    localparam logic [16:0] PLL_LAST = 17'(PLL_LOCK_CYCLES - 1);
    localparam logic [16:0] DLL_MIN_LAST = 17'(DLL_MIN_CYCLES - 1);
    localparam logic [16:0] DLL_MAX_LAST = 17'(DLL_MAX_CYCLES - 1);

    // Pin synchronisers
    logic por_s1_q, por_s2_q, por_s3_q;
    logic hrd_s1_q, hrd_s2_q, srd_s1_q, srd_s2_q;
    logic syn_s1_q, syn_s2_q, syn_s3_q;
    logic pll_s1_q, pll_s2_q, dll_s1_q, dll_s2_q;
    logic [4:0] cfg_s1_q, cfg_s2_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            {por_s1_q, por_s2_q, por_s3_q} <= 3'h0;
            {hrd_s1_q, hrd_s2_q, srd_s1_q, srd_s2_q} <= 4'hf;
            {syn_s1_q, syn_s2_q, syn_s3_q} <= 3'h0;
            {pll_s1_q, pll_s2_q, dll_s1_q, dll_s2_q} <= 4'h0;
            cfg_s1_q <= 5'h00;
            cfg_s2_q <= 5'h00;
        end else if (clk_en) begin
            por_s1_q <= power_on_reset_n;
            por_s2_q <= por_s1_q;
            por_s3_q <= por_s2_q;
            hrd_s1_q <= hard_reset_n_in;
            hrd_s2_q <= hrd_s1_q;
            srd_s1_q <= soft_reset_n_in;
            srd_s2_q <= srd_s1_q;
            syn_s1_q <= sync_clk_in;
            syn_s2_q <= syn_s1_q;
            syn_s3_q <= syn_s2_q;
            pll_s1_q <= pll_locked;
            pll_s2_q <= pll_s1_q;
            dll_s1_q <= dll_locked;
            dll_s2_q <= dll_s1_q;
            cfg_s1_q <= {host_mode_in, cfg_clkin_div_in, cfg_reset_source_in};
            cfg_s2_q <= cfg_s1_q;
        end
    end

    // Sequencer state
    seq_state_t state_q, state_d;
    logic [9:0] cnt_q, cnt_d;
    logic [16:0] wait_q, wait_d;
    logic [5:0] in_cnt_q, in_cnt_d;
    logic [1:0] rs_cnt_q, rs_cnt_d;
    logic div_q, div_d;
    logic [4:0] cap_q, cap_d;
    logic hard_oe_q, hard_oe_d, soft_oe_q, soft_oe_d;
    logic cfg_oe_q, cfg_oe_d;
    logic pll_fault_q, pll_fault_d, dll_fault_q, dll_fault_d;
    logic clk_sel_q, clk_sel_d;
    logic done_q, done_d;
    logic por_rise, tick, ext_low;

    assign por_rise = por_s2_q & ~por_s3_q;
    // Sync period: one primary clock in host mode, two when the divide setting is on; pin rising edges in agent mode
    assign tick = cap_q[4] ? (cap_q[3] ? div_q : 1'b1) : (syn_s2_q & ~syn_s3_q);
    assign ext_low = ~hrd_s2_q | ~srd_s2_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wait_d = wait_q;
        in_cnt_d = in_cnt_q;
        rs_cnt_d = rs_cnt_q;
        div_d = ~div_q;
        cap_d = cap_q;
        cfg_oe_d = cfg_oe_q;
        pll_fault_d = pll_fault_q;
        dll_fault_d = dll_fault_q;
        clk_sel_d = ~cap_q[4];
        case (state_q)
            ST_POR: begin
                if (por_rise) begin
                    cap_d = cfg_s2_q;
                    clk_sel_d = ~cfg_s2_q[4];
                    wait_d = 17'h0_0000;
                    state_d = ST_PLL;
                end
            end
            ST_PLL: begin
                wait_d = sat_inc17(wait_q);
                if (pll_s2_q || wait_q == PLL_LAST) begin
                    pll_fault_d = ~pll_s2_q;
                    wait_d = 17'h0_0000;
                    state_d = ST_DLL;
                end
            end
            ST_DLL: begin
                wait_d = sat_inc17(wait_q);
                if ((dll_s2_q && wait_q >= DLL_MIN_LAST) || wait_q == DLL_MAX_LAST) begin
                    dll_fault_d = ~dll_s2_q;
                    cnt_d = 10'h000;
                    state_d = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (tick) begin
                    if (cnt_q == DRIVE_TICKS - 10'h001) begin
                        cnt_d = 10'h000;
                        state_d = ST_HREL;
                    end else begin
                        cnt_d = cnt_q + 10'h001;
                    end
                end
            end
            ST_HREL: begin
                if (tick) begin
                    if (cnt_q == SOFT_LAG_TICKS - 10'h001) begin
                        cnt_d = 10'h000;
                        state_d = ST_RUN;
                    end else begin
                        cnt_d = cnt_q + 10'h001;
                    end
                end
            end
            ST_RUN: begin
                if (tick) begin
                    in_cnt_d = ext_low ? sat_inc6(in_cnt_q) : 6'h00;
                    if (ext_low && in_cnt_q >= INPUT_MIN_TICKS - 6'h01) begin
                        in_cnt_d = 6'h00;
                        cnt_d = 10'h000;
                        state_d = ST_DRIVE;
                    end
                end
            end
            default: begin
                state_d = ST_POR;
            end
        endcase
        if (!por_s2_q) begin
            state_d = ST_POR;
            cnt_d = 10'h000;
            in_cnt_d = 6'h00;
        end
        hard_oe_d = (state_d == ST_POR) || (state_d == ST_PLL) ||
                    (state_d == ST_DLL) || (state_d == ST_DRIVE);
        soft_oe_d = hard_oe_d || (state_d == ST_HREL);
        // Config drive released while hard reset is low on the pin or from us
        if (hard_oe_d || !hrd_s2_q) begin
            cfg_oe_d = 1'b0;
            rs_cnt_d = 2'h0;
        end else if (tick && !cfg_oe_q) begin
            if (rs_cnt_q == CFG_RESUME_TICKS) begin
                cfg_oe_d = 1'b1;
            end else begin
                rs_cnt_d = rs_cnt_q + 2'h1;
            end
        end
        done_d = (state_d == ST_RUN);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_POR;
            cnt_q <= 10'h000;
            wait_q <= 17'h0_0000;
            in_cnt_q <= 6'h00;
            rs_cnt_q <= 2'h0;
            div_q <= 1'b0;
            cap_q <= {RST_HOST_MODE, RST_CLKIN_DIV, RST_RESET_SOURCE};
            hard_oe_q <= 1'b1;
            soft_oe_q <= 1'b1;
            cfg_oe_q <= 1'b0;
            pll_fault_q <= 1'b0;
            dll_fault_q <= 1'b0;
            clk_sel_q <= ~RST_HOST_MODE;
            done_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wait_q <= wait_d;
            in_cnt_q <= in_cnt_d;
            rs_cnt_q <= rs_cnt_d;
            div_q <= div_d;
            cap_q <= cap_d;
            hard_oe_q <= hard_oe_d;
            soft_oe_q <= soft_oe_d;
            cfg_oe_q <= cfg_oe_d;
            pll_fault_q <= pll_fault_d;
            dll_fault_q <= dll_fault_d;
            clk_sel_q <= clk_sel_d;
            done_q <= done_d;
        end
    end

    // Open-drain pins: level is always low, only the enable moves
    assign hard_reset_n_out = 1'b0;
    assign soft_reset_n_out = 1'b0;
    assign hard_reset_n_oe = hard_oe_q;
    assign soft_reset_n_oe = soft_oe_q;
    assign pci_clk_select = clk_sel_q;
    assign cfg_out = cap_q[3:0];
    assign cfg_oe = cfg_oe_q;
    assign cfg_reset_source = cap_q[2:0];
    assign cfg_clkin_div = cap_q[3];
    assign host_mode = cap_q[4];
    assign seq_done = done_q;
    assign pll_fault = pll_fault_q;
    assign dll_fault = dll_fault_q;

    a_drive_length: assert property (@(posedge clock) disable iff (reset)
        $fell(hard_oe_q) |-> $past(cnt_q) == DRIVE_TICKS - 10'h001 && $past(state_q) == ST_DRIVE)
        else $error("hard reset released before full drive time");
    a_soft_lag: assert property (@(posedge clock) disable iff (reset)
        $fell(soft_oe_q) |-> $past(state_q) == ST_HREL && $past(cnt_q) == SOFT_LAG_TICKS - 10'h001)
        else $error("soft reset released too early after hard reset");
    a_soft_covers_hard: assert property (@(posedge clock) disable iff (reset)
        hard_oe_q |-> soft_oe_q)
        else $error("soft reset released while hard reset driven");
    a_cfg_off: assert property (@(posedge clock) disable iff (reset)
        clk_en && (hard_oe_d || !hrd_s2_q) |=> !cfg_oe_q)
        else $error("config pins driven during hard reset");
    a_cfg_resume: assert property (@(posedge clock) disable iff (reset)
        $rose(cfg_oe_q) |-> $past(rs_cnt_q) == CFG_RESUME_TICKS && !hard_oe_q)
        else $error("config drive resumed too soon");
    a_cfg_held: assert property (@(posedge clock) disable iff (reset)
        !(state_q == ST_POR && por_rise) |=> $stable(cap_q))
        else $error("captured config changed outside power-on release");
    a_clk_select: assert property (@(posedge clock) disable iff (reset)
        state_q != ST_POR && $past(state_q) != ST_POR |-> clk_sel_q == ~cap_q[4])
        else $error("primary clock select disagrees with mode");
    a_pll_bound: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_PLL |-> wait_q <= PLL_LAST)
        else $error("PLL wait exceeded bound");
    a_dll_window: assert property (@(posedge clock) disable iff (reset)
        clk_en && state_q == ST_DLL && state_d == ST_DRIVE |-> wait_q >= DLL_MIN_LAST)
        else $error("DLL accepted before minimum lock time");
    a_ext_trigger: assert property (@(posedge clock) disable iff (reset)
        clk_en && state_q == ST_RUN && state_d == ST_DRIVE |-> in_cnt_q >= INPUT_MIN_TICKS - 6'h01)
        else $error("reset flow started by too short an input pulse");

endmodule : reset_initialization_sequencer

`default_nettype wire

// [shared/reset_seq_pkg.sv]
package reset_seq_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_POR   = 3'b000,
        ST_PLL   = 3'b001,
        ST_DLL   = 3'b010,
        ST_DRIVE = 3'b011,
        ST_HREL  = 3'b100,
        ST_RUN   = 3'b101
    } seq_state_t;

    // Clock rate and lock timing
    localparam int CLK_MHZ = 20;
    localparam int PLL_LOCK_MAX_US = 100;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_MAX_US * CLK_MHZ;
    localparam int DLL_LOCK_MIN_CYCLES = 7680;
    localparam int DLL_LOCK_MAX_CYCLES = 122880;

    // Counts in sync clock periods
    localparam logic [9:0] DRIVE_TICKS = 10'h0200;
    localparam logic [9:0] SOFT_LAG_TICKS = 10'h0010;
    localparam logic [5:0] INPUT_MIN_TICKS = 6'h20;
    localparam logic [1:0] CFG_RESUME_TICKS = 2'h1;

    // Reset values
    localparam logic [2:0] RST_RESET_SOURCE = 3'h0;
    localparam logic RST_CLKIN_DIV = 1'b0;
    localparam logic RST_HOST_MODE = 1'b1;

    // Saturating counter step
    function automatic logic [16:0] sat_inc17(input logic [16:0] v);
        sat_inc17 = (v == 17'h1_ffff) ? v : v + 17'h0_0001;
    endfunction : sat_inc17

    function automatic logic [5:0] sat_inc6(input logic [5:0] v);
        sat_inc6 = (v == 6'h3f) ? v : v + 6'h01;
    endfunction : sat_inc6

endpackage : reset_seq_pkg

// [tb/board_model.sv]
`timescale 1ns/1ns
`default_nettype none

module board_model (
    // Clock and control from bench
    input wire logic clock,
    input wire logic por_rel,
    input wire logic ext_hard_low,
    input wire logic lock_hold,
    // Device open-drain enables
    input wire logic hard_oe,
    input wire logic soft_oe,
    // Board side outputs
    output logic power_on_reset_n,
    output logic hard_wire,
    output logic soft_wire,
    output logic sync_clk,
    output logic pll_locked,
    output logic dll_locked
);
    logic [7:0] lock_cnt_q;

    initial begin
        sync_clk = 1'b0;
    end

    // Sync clock, one rising edge every two primary cycles
    always @(negedge clock) begin
        sync_clk <= ~sync_clk;
    end

    // Bench holds it low 32 periods and more
    assign power_on_reset_n = por_rel;

    // Pull-ups; device or bench may pull hard low, only the device pulls soft low
    assign hard_wire = !(hard_oe || ext_hard_low);
    assign soft_wire = !soft_oe;

    always @(posedge clock) begin
        if (!power_on_reset_n) begin
            lock_cnt_q <= 8'h00;
        end else if (lock_cnt_q != 8'hff) begin
            lock_cnt_q <= lock_cnt_q + 8'h01;
        end
    end

    // Lock hold keeps both loops unlocked to force the timeouts
    assign pll_locked = (lock_cnt_q >= 8'h14) && !lock_hold;
    assign dll_locked = (lock_cnt_q >= 8'h28) && !lock_hold;
endmodule : board_model

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clock, reset, por_rel, ext_hard_low, host, div, en, lock_hold;
    logic pll_f, dll_f;
    logic [2:0] src;
    logic por_n, hard_wire, soft_wire, sync_clk, pll_l, dll_l;
    logic hard_out, hard_oe, soft_out, soft_oe, pci_sel, cfg_oe, cfg_div, host_m, done;
    logic [3:0] cfg_out;
    logic [2:0] cfg_src;
    int err_total, checks, n;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t mismatch", $time); end end

    board_model i_board (.clock(clock), .por_rel(por_rel), .ext_hard_low(ext_hard_low),
        .lock_hold(lock_hold),
        .hard_oe(hard_oe), .soft_oe(soft_oe), .power_on_reset_n(por_n),
        .hard_wire(hard_wire), .soft_wire(soft_wire), .sync_clk(sync_clk),
        .pll_locked(pll_l), .dll_locked(dll_l));

    reset_initialization_sequencer #(.DLL_MIN_CYCLES(8), .DLL_MAX_CYCLES(64)) i_dut (
        .clock(clock), .reset(reset), .clk_en(en), .power_on_reset_n(por_n),
        .hard_reset_n_in(hard_wire), .hard_reset_n_out(hard_out),
        .hard_reset_n_oe(hard_oe), .soft_reset_n_in(soft_wire),
        .soft_reset_n_out(soft_out), .soft_reset_n_oe(soft_oe), .sync_clk_in(sync_clk),
        .pll_locked(pll_l), .dll_locked(dll_l), .pci_clk_select(pci_sel),
        .host_mode_in(host), .cfg_reset_source_in(src), .cfg_clkin_div_in(div),
        .cfg_out(cfg_out), .cfg_oe(cfg_oe), .cfg_reset_source(cfg_src),
        .cfg_clkin_div(cfg_div), .host_mode(host_m), .seq_done(done),
        .pll_fault(pll_f), .dll_fault(dll_f));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic t_reset_values;
        `CHK(hard_oe, 1'b1)
        `CHK(cfg_oe, 1'b0)
        `CHK(pci_sel, 1'b0)
        `CHK(hard_out, 1'b0)
        `CHK(soft_out, 1'b0)
    endtask : t_reset_values

    task automatic t_host_flow;
        host = 1'b1;
        div = 1'b0;
        src = 3'h5;
        repeat (40) @(negedge clock);
        por_rel = 1'b1;
        n = 0;
        while (hard_oe !== 1'b0 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        `CHK(soft_oe, 1'b1)
        `CHK(cfg_oe, 1'b0)
        n = 0;
        while (soft_oe !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        `CHK(n >= 16, 1'b1)
        `CHK(n <= 17, 1'b1)
        repeat (4) @(negedge clock);
        `CHK(cfg_oe, 1'b1)
        `CHK(cfg_out, 4'h5)
        `CHK(done, 1'b1)
        `CHK(pci_sel, 1'b0)
        `CHK(host_m, 1'b1)
        `CHK(pll_f, 1'b0)
        `CHK(dll_f, 1'b0)
    endtask : t_host_flow

    task automatic t_retrigger;
        ext_hard_low = 1'b1;
        repeat (20) @(negedge clock);
        `CHK(cfg_oe, 1'b0)
        `CHK(hard_oe, 1'b0)
        ext_hard_low = 1'b0;
        repeat (10) @(negedge clock);
        `CHK(hard_oe, 1'b0)
        `CHK(done, 1'b1)
        ext_hard_low = 1'b1;
        repeat (40) @(negedge clock);
        `CHK(hard_oe, 1'b1)
        ext_hard_low = 1'b0;
        n = 0;
        while (hard_oe === 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        `CHK(n >= 505 && n <= 507, 1'b1)
        `CHK(hard_oe, 1'b0)
    endtask : t_retrigger

    task automatic t_agent;
        por_rel = 1'b0;
        repeat (4) @(negedge clock);
        `CHK(hard_oe, 1'b1)
        host = 1'b0;
        div = 1'b1;
        src = 3'h2;
        repeat (80) @(negedge clock);
        por_rel = 1'b1;
        repeat (10) @(negedge clock);
        `CHK(pci_sel, 1'b1)
        `CHK(host_m, 1'b0)
        `CHK(cfg_src, 3'h2)
        `CHK(cfg_div, 1'b1)
        n = 0;
        while (hard_oe !== 1'b0 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        `CHK(hard_oe, 1'b0)
        n = 0;
        while (soft_oe !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        `CHK(n, 32)
        // Straps move only after hard reset has negated
        host = 1'b1;
        div = 1'b0;
        src = 3'h7;
        repeat (10) @(negedge clock);
        `CHK(cfg_src, 3'h2)
        `CHK(cfg_out, 4'ha)
        `CHK(cfg_oe, 1'b1)
        `CHK(pci_sel, 1'b1)
        `CHK(done, 1'b1)
    endtask : t_agent

    task automatic t_lock_fault;
        por_rel = 1'b0;
        lock_hold = 1'b1;
        host = 1'b1;
        div = 1'b1;
        src = 3'h3;
        repeat (80) @(negedge clock);
        por_rel = 1'b1;
        repeat (20) @(negedge clock);
        // Enable low for 100 cycles must stretch the flow by 100 cycles
        en = 1'b0;
        repeat (100) @(negedge clock);
        `CHK(hard_oe, 1'b1)
        en = 1'b1;
        n = 0;
        while (hard_oe !== 1'b0 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        `CHK(n >= 3069 && n <= 3072, 1'b1)
        `CHK(pll_f, 1'b1)
        `CHK(dll_f, 1'b1)
        `CHK(pci_sel, 1'b0)
        n = 0;
        while (soft_oe !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        `CHK(n, 32)
        lock_hold = 1'b0;
    endtask : t_lock_fault

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end

    initial begin
        err_total = 0;
        checks = 0;
        reset = 1'b1;
        por_rel = 1'b0;
        ext_hard_low = 1'b0;
        en = 1'b1;
        lock_hold = 1'b0;
        host = 1'b1;
        div = 1'b0;
        src = 3'h0;
        repeat (4) @(negedge clock);
        reset = 1'b0;
        t_reset_values();
        t_host_flow();
        t_retrigger();
        t_agent();
        t_lock_fault();
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
